// [dcps_top.sv]
// dcps_top: supply path selection, charger steering and status registers
`timescale 1ns/1ns
`default_nettype none
module dcps_top
    import dcps_pkg::*;
#(
    parameter int unsigned P_RESUME_CYCLES = RESUME_CYCLES
)
(
    // clock and reset
    input  wire logic       i_core_clk,
    input  wire logic       i_resetn,
    // primary cell comparators
    input  wire logic       i_pri_ge_lower,
    input  wire logic       i_pri_ge_lower_hys,
    input  wire logic       i_pri_ge_upper,
    input  wire logic       i_pri_ge_upper_hys,
    input  wire logic       i_pri_ge_full,
    // secondary cell comparators
    input  wire logic       i_sec_ge_lower,
    input  wire logic       i_sec_ge_lower_hys,
    input  wire logic       i_sec_ge_upper,
    input  wire logic       i_sec_ge_upper_hys,
    input  wire logic       i_sec_ge_full,
    input  wire logic       i_sec_ge_resume,
    // pins
    input  wire logic       i_primary_detect_pin,
    input  wire logic       i_secondary_detect_pin,
    input  wire logic       i_adapter_present,
    // register port
    input  wire logic [7:0] i_reg_addr,
    input  wire logic [7:0] i_reg_wdata,
    input  wire logic       i_reg_wr,
    input  wire logic       i_reg_rd,
    output logic      [7:0] o_reg_rdata,
    // comparator level selects
    output logic            o_upper_thr_sel,
    output logic            o_lower_thr_sel,
    output logic            o_margin_fine,
    // path switches and charger
    output logic            o_primary_switch_on,
    output logic            o_secondary_switch_on,
    output logic            o_chg_primary_en,
    output logic            o_chg_primary_high,
    output logic            o_chg_secondary_en,
    output logic            o_chg_secondary_high,
    // status interrupt
    output logic            o_status_irq_n
);
    // =========================================================
    // input synchronisation
    dcps_cmp_if cmp ();

    logic [SYNC_W-1:0] raw_in;

    assign raw_in = {i_sec_ge_resume, i_adapter_present,
                     i_secondary_detect_pin, i_primary_detect_pin,
                     i_sec_ge_full, i_sec_ge_upper_hys, i_sec_ge_upper,
                     i_sec_ge_lower_hys, i_sec_ge_lower,
                     i_pri_ge_full, i_pri_ge_upper_hys, i_pri_ge_upper,
                     i_pri_ge_lower_hys, i_pri_ge_lower};

    dcps_sync u_sync (
        .i_core_clk (i_core_clk),
        .i_resetn   (i_resetn),
        .i_async    (raw_in),
        .o_cmp      (cmp)
    );

    // =========================================================
    // effective cell levels; a missing cell counts as empty
    logic [CMP_W-1:0] p_c;
    logic [CMP_W-1:0] s_c;
    logic             p_in;
    logic             s_in;
    logic             adapter;

    assign p_in    = cmp.pri_det;
    assign s_in    = cmp.sec_det;
    assign adapter = cmp.adapter;
    assign p_c     = cmp.pri_cmp & {CMP_W{p_in}};
    assign s_c     = cmp.sec_cmp & {CMP_W{s_in}};

    logic p_lower;
    logic p_lower_hys;
    logic p_upper_hys;
    logic p_full;
    logic s_lower;
    logic s_lower_hys;
    logic s_upper;
    logic s_full;

    assign p_lower     = p_c[CMP_LOWER];
    assign p_lower_hys = p_c[CMP_LOWER_HYS];
    assign p_upper_hys = p_c[CMP_UPPER_HYS];
    assign p_full      = p_c[CMP_FULL];
    assign s_lower     = s_c[CMP_LOWER];
    assign s_lower_hys = s_c[CMP_LOWER_HYS];
    assign s_upper     = s_c[CMP_UPPER];
    assign s_full      = s_c[CMP_FULL];

    // =========================================================
    // register port decode
    logic [CFG_W-1:0] cfg_reg;
    logic [CFG_W-1:0] cfg_next;
    logic             wr_cfg;
    logic             soft_rst;
    logic             rd_state;

    assign wr_cfg   = i_reg_wr && (i_reg_addr == ADDR_CONFIG);
    assign soft_rst = i_reg_wr && (i_reg_addr == ADDR_RESET)
                      && (i_reg_wdata == RESET_KEY);
    assign rd_state = i_reg_rd && (i_reg_addr == ADDR_STATE);

    logic [1:0] sel;
    logic       chg_off;

    assign sel     = cfg_reg[CFG_SEL_HI:CFG_SEL_LO];
    assign chg_off = cfg_reg[CFG_OFF];

    // reset key wins over a config write, they cannot coincide anyway
    assign cfg_next = soft_rst ? CFG_DEFAULT
                    : wr_cfg   ? i_reg_wdata[CFG_W-1:0] : cfg_reg;

    // =========================================================
    // automatic source selection, charge rules
    dcps_src_t src_reg;
    dcps_src_t src_next;
    dcps_src_t auto_next;
    logic      both_ok;
    logic      back_ok;

    // which hysteresis applies depends on where the secondary sits
    assign back_ok = s_upper ? p_upper_hys : p_lower_hys;

    always_comb begin
        auto_next = src_reg;
        unique case (src_reg)
            SRC_PRIMARY: begin
                if (!p_lower) begin
                    auto_next = s_lower ? SRC_SECONDARY : SRC_NONE;
                end
            end
            SRC_SECONDARY: begin
                if (back_ok) begin
                    auto_next = SRC_PRIMARY;
                end else if (!s_lower) begin
                    auto_next = SRC_NONE;
                end
            end
            SRC_NONE: begin
                // primary wins a tie, it is the preferred source
                if (p_lower_hys) begin
                    auto_next = SRC_PRIMARY;
                end else if (s_lower_hys) begin
                    auto_next = SRC_SECONDARY;
                end
            end
            default: begin
                auto_next = SRC_NONE;
            end
        endcase
    end

    // discharge switching is not handled here: without adapter, only a forced select changes the source
    assign both_ok  = p_lower && s_lower;
    assign src_next = (sel == SEL_PRIMARY && both_ok) ? SRC_PRIMARY
                    : (sel == SEL_SECOND  && both_ok) ? SRC_SECONDARY
                    : adapter ? auto_next : src_reg;

    // =========================================================
    // internal charger steering
    logic chg_on;
    logic both_full;
    logic chg_pri_next;
    logic chg_sec_next;
    logic sec_stop_reg;
    logic sec_stop_next;
    logic resume_done;

    assign chg_on       = adapter && !chg_off;
    assign both_full    = p_full && s_full;
    assign chg_pri_next = chg_on && !both_full && p_in
                          && (src_next != SRC_PRIMARY);
    assign chg_sec_next = chg_on && !both_full && s_in && !sec_stop_reg
                          && (src_next != SRC_SECONDARY);

    // a new full reading wins over the resume event
    assign sec_stop_next = s_full || (sec_stop_reg && !resume_done);

    dcps_hold_timer #(
        .P_CYCLES (P_RESUME_CYCLES)
    ) u_resume (
        .i_core_clk (i_core_clk),
        .i_resetn   (i_resetn),
        .i_run      (sec_stop_reg && !(cmp.sec_resume && s_in)),
        .o_done     (resume_done)
    );

    // =========================================================
    // state register and interrupt
    logic [7:0] state_reg;
    logic [7:0] state_next;
    logic       irq_n_reg;
    logic       irq_set;
    logic       irq_n_next;

    assign state_next = {~cmp.sec_det, ~cmp.pri_det,
                         src_next,
                         level_code(s_c), level_code(p_c)};

    // set wins over the clearing read
    assign irq_set    = (state_next != state_reg) || soft_rst;
    assign irq_n_next = !(irq_set || (!irq_n_reg && !rd_state));

    logic [7:0] cfg_view;
    logic [7:0] rdata_next;

    assign cfg_view   = {~o_chg_secondary_en, ~o_chg_primary_en, cfg_reg[CFG_SEL_HI:0]};
    assign rdata_next = !i_reg_rd                   ? o_reg_rdata
                      : (i_reg_addr == ADDR_STATE)  ? state_reg
                      : (i_reg_addr == ADDR_CONFIG) ? cfg_view : RDATA_NONE;

    // =========================================================
    // registers
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cfg_reg               <= CFG_DEFAULT;
            src_reg               <= SRC_NONE;
            sec_stop_reg          <= 1'b0;
            state_reg             <= STATE_RESET;
            irq_n_reg             <= 1'b0;
            o_reg_rdata           <= RDATA_NONE;
            o_upper_thr_sel       <= 1'b0;
            o_lower_thr_sel       <= 1'b0;
            o_margin_fine         <= 1'b0;
            o_primary_switch_on   <= 1'b0;
            o_secondary_switch_on <= 1'b0;
            o_chg_primary_en      <= 1'b0;
            o_chg_primary_high    <= 1'b0;
            o_chg_secondary_en    <= 1'b0;
            o_chg_secondary_high  <= 1'b0;
        end else begin
            cfg_reg               <= cfg_next;
            src_reg               <= src_next;
            sec_stop_reg          <= sec_stop_next;
            state_reg             <= state_next;
            irq_n_reg             <= irq_n_next;
            o_reg_rdata           <= rdata_next;
            o_upper_thr_sel       <= cfg_next[CFG_UPPER];
            o_lower_thr_sel       <= cfg_next[CFG_LOWER];
            o_margin_fine         <= cfg_next[CFG_MRG_HI:CFG_MRG_LO] == MRG_FINE;
            o_primary_switch_on   <= src_next == SRC_PRIMARY;
            o_secondary_switch_on <= src_next == SRC_SECONDARY;
            o_chg_primary_en      <= chg_pri_next;
            o_chg_primary_high    <= chg_pri_next && p_lower;
            o_chg_secondary_en    <= chg_sec_next;
            o_chg_secondary_high  <= chg_sec_next && s_lower;
        end
    end

    assign o_status_irq_n = irq_n_reg;

    // =========================================================
    // checks
    a_trickle_below_lower: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        o_chg_secondary_en && !$past(s_lower) |-> !o_chg_secondary_high)
        else $error("secondary fed high current below lower threshold");

    a_full_stops_charger: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        both_full |=> !o_chg_primary_en && !o_chg_secondary_en)
        else $error("charger still on with both cells full");

    a_secondary_takes_rail: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        src_reg == SRC_PRIMARY && adapter && sel == SEL_AUTO && !p_lower && s_lower
        |=> src_reg == SRC_SECONDARY && o_secondary_switch_on)
        else $error("secondary did not take the rail");

    a_both_low_cutoff: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        adapter && sel == SEL_AUTO && !p_lower && !s_lower && src_reg != SRC_NONE
        |=> src_reg == SRC_NONE && !o_primary_switch_on && !o_secondary_switch_on)
        else $error("rail not cut off with both cells low");

    a_hold_until_margin: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        src_reg == SRC_SECONDARY && adapter && sel == SEL_AUTO && s_lower && s_upper
        && !p_upper_hys |=> src_reg == SRC_SECONDARY)
        else $error("switched back before the margin was reached");

    a_charger_off_bit: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        chg_off && !wr_cfg |=> !o_chg_primary_en && !o_chg_secondary_en)
        else $error("charger on although switched off");

    a_forced_primary: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        sel == SEL_PRIMARY && both_ok |=> o_primary_switch_on && !o_secondary_switch_on)
        else $error("forced primary selection not honoured");

    a_read_clears_irq: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        rd_state && !irq_set |=> o_status_irq_n)
        else $error("state read did not release the interrupt");

    a_change_raises_irq: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        state_next != state_reg |=> !o_status_irq_n ##1 (!o_status_irq_n || $past(rd_state)))
        else $error("status change did not raise the interrupt");

    a_reset_key_defaults: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        soft_rst |=> cfg_reg == CFG_DEFAULT && !o_status_irq_n)
        else $error("reset key did not restore defaults");

    a_presence_flags: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        ##1 state_reg[7:6] == ~$past({cmp.sec_det, cmp.pri_det}))
        else $error("presence flags do not follow the detect pins");

    a_secondary_stop: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        s_full ##1 !resume_done |=> !o_chg_secondary_en)
        else $error("full secondary still charged");
endmodule
`default_nettype wire

// [dcps_pkg.sv]
// dcps_pkg: shared constants, codes and types of the dual cell path selector
// Behaviour
// - unused cell: 20mA below lower, then 150mA
// - charger off once both cells full
// - primary low, secondary high: secondary supplies
// - primary low, secondary mid: secondary supplies
// - both low: rail disconnected, both trickled
// - secondary high: primary returns at upper+margin
// - secondary mid: primary returns at lower+0.1V
// - first cell past lower+0.1V supplies
// - secondary stops full, resumes after 2s low
// - switch back only past threshold plus hysteresis
// - margin field: 00 0.1V, 01 0.05V
// - charger-off bit: 0 on, 1 off
// - supply select: auto, force primary, secondary
// - forcing only while both above lower
// - threshold select bits pick comparator levels
// - secondary flag inverts secondary detect pin
// - primary flag inverts primary detect pin
// - source field: 00 primary, 01 secondary, 11 none
// - secondary level code from comparators
// - primary level code, same four codes
// - latched low interrupt, cleared by state read
// - reset key write restores register defaults
package dcps_pkg;

    // =========================================================
    // register map
    localparam logic [7:0] ADDR_STATE  = 8'h00;
    localparam logic [7:0] ADDR_CONFIG = 8'h01;
    localparam logic [7:0] ADDR_RESET  = 8'h0F;
    localparam logic [7:0] RESET_KEY   = 8'h00;
    localparam logic [7:0] RDATA_NONE  = 8'h00;
    // cells out, no source, both levels low
    localparam logic [7:0] STATE_RESET = 8'hF0;

    // =========================================================
    // configuration fields (stored bits 6:0)
    localparam int         CFG_W        = 7;
    localparam logic [6:0] CFG_DEFAULT  = 7'h00;
    localparam int         CFG_LOWER    = 0;
    localparam int         CFG_UPPER    = 1;
    localparam int         CFG_MRG_LO   = 2;
    localparam int         CFG_MRG_HI   = 3;
    localparam int         CFG_SEL_LO   = 4;
    localparam int         CFG_SEL_HI   = 5;
    localparam int         CFG_OFF      = 6;
    localparam logic [1:0] SEL_AUTO     = 2'h0;
    localparam logic [1:0] SEL_PRIMARY  = 2'h1;
    localparam logic [1:0] SEL_SECOND   = 2'h2;
    localparam logic [1:0] MRG_FINE     = 2'h1;

    // =========================================================
    // cell level codes
    localparam logic [1:0] LVL_LOW  = 2'h0;
    localparam logic [1:0] LVL_MID  = 2'h1;
    localparam logic [1:0] LVL_HIGH = 2'h2;
    localparam logic [1:0] LVL_FULL = 2'h3;

    // =========================================================
    // comparator vector layout, one vector per cell
    localparam int CMP_LOWER     = 0;
    localparam int CMP_LOWER_HYS = 1;
    localparam int CMP_UPPER     = 2;
    localparam int CMP_UPPER_HYS = 3;
    localparam int CMP_FULL      = 4;
    localparam int CMP_W         = 5;
    localparam int SYNC_W        = 2 * CMP_W + 4;

    // =========================================================
    // timing
    localparam longint CLK_HZ         = 20000000;
    localparam longint MS_PER_S       = 1000;
    localparam longint RESUME_TIME_MS = 2000;
    localparam int unsigned RESUME_CYCLES =
        int'(RESUME_TIME_MS * (CLK_HZ / MS_PER_S));
    localparam int TMR_W = 26;

    // =========================================================
    // supply source, codes equal the reported source field
    typedef enum logic [1:0] {
        SRC_PRIMARY   = 2'b00,
        SRC_SECONDARY = 2'b01,
        SRC_NONE      = 2'b11
    } dcps_src_t;

    function automatic logic [1:0] level_code(input logic [CMP_W-1:0] c);
        logic [1:0] v;
        v = LVL_LOW;
        if (c[CMP_FULL]) begin
            v = LVL_FULL;
        end else if (c[CMP_UPPER]) begin
            v = LVL_HIGH;
        end else if (c[CMP_LOWER]) begin
            v = LVL_MID;
        end
        return v;
    endfunction

endpackage

// [dcps_cmp_if.sv]
// dcps_cmp_if: synchronised comparator and pin levels
`timescale 1ns/1ns
`default_nettype none
interface dcps_cmp_if;
    import dcps_pkg::*;
    logic [CMP_W-1:0] pri_cmp;
    logic [CMP_W-1:0] sec_cmp;
    logic             pri_det;
    logic             sec_det;
    logic             adapter;
    logic             sec_resume;
    modport src (output pri_cmp, sec_cmp, pri_det, sec_det, adapter, sec_resume);
    modport dst (input  pri_cmp, sec_cmp, pri_det, sec_det, adapter, sec_resume);
endinterface
`default_nettype wire

// [dcps_sync.sv]
// dcps_sync: two-stage synchroniser for all analog and pin inputs
`timescale 1ns/1ns
`default_nettype none
module dcps_sync
    import dcps_pkg::*;
(
    // clock and reset
    input  wire logic              i_core_clk,
    input  wire logic              i_resetn,
    // raw levels
    input  wire logic [SYNC_W-1:0] i_async,
    // synchronised levels
    dcps_cmp_if.src                o_cmp
);
    logic [SYNC_W-1:0] meta_reg;
    logic [SYNC_W-1:0] sync_reg;

    // =========================================================
    // stages; meta_reg feeds sync_reg only
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_cmp.pri_cmp    = sync_reg[CMP_W-1:0];
    assign o_cmp.sec_cmp    = sync_reg[2*CMP_W-1:CMP_W];
    assign o_cmp.pri_det    = sync_reg[2*CMP_W];
    assign o_cmp.sec_det    = sync_reg[2*CMP_W+1];
    assign o_cmp.adapter    = sync_reg[2*CMP_W+2];
    assign o_cmp.sec_resume = sync_reg[2*CMP_W+3];
endmodule
`default_nettype wire

// [dcps_hold_timer.sv]
// dcps_hold_timer: flags a level that has held for a set number of cycles
`timescale 1ns/1ns
`default_nettype none
module dcps_hold_timer
    import dcps_pkg::*;
#(
    parameter int unsigned P_CYCLES = RESUME_CYCLES
)
(
    // clock and reset
    input  wire logic i_core_clk,
    input  wire logic i_resetn,
    // level under watch and result
    input  wire logic i_run,
    output logic      o_done
);
    localparam logic [TMR_W-1:0] LAST = TMR_W'(P_CYCLES - 1);

    logic [TMR_W-1:0] cnt_reg;
    logic [TMR_W-1:0] cnt_next;
    logic             done_reg;
    logic             done_next;

    // =========================================================
    // any break in the level restarts the wait
    assign cnt_next  = !i_run ? '0 : (cnt_reg == LAST) ? cnt_reg : cnt_reg + 1'b1;
    assign done_next = i_run && (cnt_reg == LAST);

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_reg  <= '0;
            done_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            done_reg <= done_next;
        end
    end

    assign o_done = done_reg;

    a_done_after_hold: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        $rose(done_reg) |-> $past(cnt_reg) == LAST && $past(i_run))
        else $error("hold timer done before the full wait");
endmodule
`default_nettype wire

// [dcps_host.sv]
// dcps_host: register-port host model, single-byte reads and writes
`timescale 1ns/1ns
`default_nettype none
module dcps_host (
    // clock and read data
    input  wire logic       i_core_clk,
    input  wire logic [7:0] i_reg_rdata,
    // register port strobes
    output logic      [7:0] o_reg_addr,
    output logic      [7:0] o_reg_wdata,
    output logic            o_reg_wr,
    output logic            o_reg_rd
);
    // ========================================
    // bus cycles
    initial begin
        o_reg_addr  = 8'h00;
        o_reg_wdata = 8'h00;
        o_reg_wr    = 1'b0;
        o_reg_rd    = 1'b0;
    end
    // the reset key goes out like any other byte
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge i_core_clk);
        o_reg_addr  <= a;
        o_reg_wdata <= v;
        o_reg_wr    <= 1'b1;
        @(posedge i_core_clk);
        o_reg_wr    <= 1'b0;
        // data changes each write, never left as a stale copy
        o_reg_wdata <= ~v;
    endtask
    // strobe held to the taking edge, data picked up at the falling edge half a cycle on
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
        @(posedge i_core_clk);
        o_reg_addr <= a;
        o_reg_rd   <= 1'b1;
        @(posedge i_core_clk);
        o_reg_rd   <= 1'b0;
        @(negedge i_core_clk);
        v = i_reg_rdata;
    endtask
endmodule
`default_nettype wire

// [dcps_top_tb.sv]
// dcps_top_tb: self-checking bench of the path selector
`timescale 1ns/1ns
`default_nettype none
module dcps_top_tb;
    import dcps_pkg::*;
    // ========================================
    // stimulus and observation
    logic        clk  = 1'b0;
    logic        rstn = 1'b0;
    logic [4:0]  pri  = 5'h00;
    logic [4:0]  sec  = 5'h00;
    logic        pdet = 1'b1;
    logic        sdet = 1'b1;
    logic        sres = 1'b0;
    logic        adp  = 1'b1;
    logic [7:0]  addr, wdata, rdata, d;
    logic        wr, rd, uthr, lthr, fine, psw, ssw, pen, phi, sen, shi, irq_n;
    int          n_mismatch = 0;
    int          checked    = 0;
    // rows: primary cmp, secondary cmp, state, {psw,ssw,pen,phi,sen,shi}
    logic [23:0] rows [8] = '{
        {5'h00, 5'h00, 8'h30, 6'h0A}, {5'h03, 5'h00, 8'h01, 6'h22},
        {5'h00, 5'h07, 8'h18, 6'h18}, {5'h03, 5'h07, 8'h19, 6'h1C},
        {5'h0F, 5'h07, 8'h0A, 6'h23}, {5'h00, 5'h03, 8'h14, 6'h18},
        {5'h03, 5'h03, 8'h05, 6'h23}, {5'h1F, 5'h1F, 8'h0F, 6'h20}};
    // ========================================
    // clock, instances
    initial begin
        forever #25 clk = ~clk;
    end
    dcps_host host_u (.i_core_clk(clk), .i_reg_rdata(rdata), .o_reg_addr(addr),
        .o_reg_wdata(wdata), .o_reg_wr(wr), .o_reg_rd(rd));
    dcps_top #(.P_RESUME_CYCLES(20)) dut_u (.i_core_clk(clk), .i_resetn(rstn),
        .i_pri_ge_lower(pri[0]), .i_pri_ge_lower_hys(pri[1]), .i_pri_ge_upper(pri[2]),
        .i_pri_ge_upper_hys(pri[3]), .i_pri_ge_full(pri[4]), .i_sec_ge_lower(sec[0]),
        .i_sec_ge_lower_hys(sec[1]), .i_sec_ge_upper(sec[2]), .i_sec_ge_upper_hys(sec[3]),
        .i_sec_ge_full(sec[4]), .i_sec_ge_resume(sres), .i_primary_detect_pin(pdet),
        .i_secondary_detect_pin(sdet), .i_adapter_present(adp), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
        .o_upper_thr_sel(uthr), .o_lower_thr_sel(lthr), .o_margin_fine(fine),
        .o_primary_switch_on(psw), .o_secondary_switch_on(ssw), .o_chg_primary_en(pen),
        .o_chg_primary_high(phi), .o_chg_secondary_en(sen),
        .o_chg_secondary_high(shi), .o_status_irq_n(irq_n));
    // ========================================
    // checking and verdict
    task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
        checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // settle covers two sync stages plus the state register
    task automatic settle;
        repeat (4) @(posedge clk);
        #1;
    endtask
    // hang guard
    initial begin
        repeat (3000) @(posedge clk);
        n_mismatch++;
        results;
    end
    // ========================================
    // main sequence
    initial begin
        repeat (5) @(posedge clk);
        #1;
        chk("rst_out", {psw, ssw, irq_n, rdata[0]}, 8'h00);
        @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            pri  <= rows[i][23:19];
            sec  <= rows[i][18:14];
            sres <= rows[i][18];
            settle;
            chk("irq_set", {7'h0, irq_n}, 8'h00);
            chk("paths", {2'h0, psw, ssw, pen, phi, sen, shi}, {2'h0, rows[i][5:0]});
            host_u.rd_reg(ADDR_STATE, d);
            chk("state", d, rows[i][13:6]);
            chk("irq_clr", {7'h0, irq_n}, 8'h01);
        end
        // forced secondary, fine margin, high thresholds
        host_u.wr_reg(ADDR_CONFIG, 8'h27);
        settle;
        chk("cfg_out", {3'h0, uthr, lthr, fine, psw, ssw}, 8'h1D);
        host_u.rd_reg(ADDR_CONFIG, d);
        chk("cfg_rd", d, 8'hE7);
        host_u.wr_reg(ADDR_RESET, 8'h01);
        settle;
        chk("bad_key", {7'h0, fine}, 8'h01);
        host_u.wr_reg(ADDR_RESET, RESET_KEY);
        settle;
        chk("key", {4'h0, uthr, lthr, fine, irq_n}, 8'h00);
        chk("auto", {6'h0, psw, ssw}, 8'h02);
        // charger off bit; full secondary stays stopped above resume level
        @(posedge clk);
        pri <= 5'h03;
        sec <= 5'h0F;
        host_u.wr_reg(ADDR_CONFIG, 8'h40);
        settle;
        chk("chg_off", {6'h0, pen, sen}, 8'h00);
        host_u.wr_reg(ADDR_CONFIG, 8'h00);
        settle;
        chk("sec_held", {6'h0, sen, shi}, 8'h00);
        @(posedge clk);
        sres <= 1'b0;
        repeat (22) @(posedge clk);
        #1;
        chk("sec_wait", {6'h0, sen, shi}, 8'h00);
        repeat (4) @(posedge clk);
        #1;
        chk("chg_on", {6'h0, sen, shi}, 8'h03);
        // adapter pulled: charger idles, source held
        @(posedge clk);
        adp <= 1'b0;
        settle;
        chk("no_adapter", {5'h0, psw, pen, sen}, 8'h04);
        @(posedge clk);
        adp <= 1'b1;
        // forcing, and its release once a cell drops below lower
        host_u.wr_reg(ADDR_CONFIG, 8'h20);
        settle;
        chk("force_sec", {6'h0, psw, ssw}, 8'h01);
        host_u.wr_reg(ADDR_CONFIG, 8'h10);
        settle;
        chk("force_pri", {6'h0, psw, ssw}, 8'h02);
        host_u.wr_reg(ADDR_CONFIG, 8'h20);
        @(posedge clk);
        sec <= 5'h00;
        settle;
        chk("force_low", {6'h0, psw, ssw}, 8'h02);
        host_u.wr_reg(ADDR_CONFIG, 8'h00);
        host_u.rd_reg(8'h05, d);
        chk("unmapped", d, RDATA_NONE);
        // both cells pulled out
        @(posedge clk);
        pdet <= 1'b0;
        sdet <= 1'b0;
        settle;
        host_u.rd_reg(ADDR_STATE, d);
        chk("absent", d, 8'hF0);
        // pin reset in mid-run brings back the startup interrupt
        @(posedge clk);
        rstn <= 1'b0;
        @(posedge clk);
        #1;
        chk("rst_mid", {psw, ssw, irq_n, pen}, 8'h00);
        @(posedge clk);
        rstn <= 1'b1;
        settle;
        chk("rst_irq", {7'h0, irq_n}, 8'h00);
        results;
    end
endmodule
`default_nettype wire
